// >>> include/eiap_params.svh
// offsets, field positions, reset values and timing counts of the assembly producer
`ifndef EIAP_PARAMS_SVH
`define EIAP_PARAMS_SVH

`define EIAP_OFS_CTRL      8'h00
`define EIAP_OFS_DIR       8'h04
`define EIAP_OFS_SCALE     8'h08
`define EIAP_OFS_UNITS     8'h0C
`define EIAP_OFS_RANGE     8'h10
`define EIAP_OFS_PRESET    8'h14
`define EIAP_OFS_POSITION  8'h18
`define EIAP_OFS_RESOL     8'h1C
`define EIAP_OFS_ALARM     8'h20
`define EIAP_OFS_TYPE      8'h24
`define EIAP_OFS_VERSION   8'h28
`define EIAP_OFS_OFFSET    8'h2C
`define EIAP_OFS_CYC_MS    8'h30
`define EIAP_OFS_IRQ_STAT  8'h34
`define EIAP_OFS_IRQ_MASK  8'h38
`define EIAP_OFS_CONN_STAT 8'h3C

`define EIAP_CTRL_POLL   0
`define EIAP_CTRL_STROBE 1
`define EIAP_CTRL_COS    2
`define EIAP_CTRL_CYC    3
`define EIAP_CTRL_ASM    4

`define EIAP_IRQ_SENT   0
`define EIAP_IRQ_ALARM  1
`define EIAP_IRQ_PRESET 2

`define EIAP_CTRL_RST   5'h10
`define EIAP_CYC_MS_RST 16'h0064
`define EIAP_LEN_INST1  3'h4
`define EIAP_LEN_INST2  3'h5

`define EIAP_CLK_NS   100
`define EIAP_TICK_NS  1000000
`define EIAP_TICK_CYC (`EIAP_TICK_NS / `EIAP_CLK_NS)

`endif

// >>> include/eiap_pkg.sv
// types shared by the assembly producer files
package eiap_pkg;
  typedef enum logic [2:0]
  {
    EIAP_SRC_NONE   = 3'b000,
    EIAP_SRC_POLL   = 3'b001,
    EIAP_SRC_STROBE = 3'b010,
    EIAP_SRC_COS    = 3'b011,
    EIAP_SRC_CYC    = 3'b100
  } eiap_src_e;
  typedef logic [39:0] eiap_payload_t;
endpackage

// >>> rtl/eiap_ser.sv
// byte serialiser for one assembly payload
`timescale 1ns/1ps
module eiap_ser
(
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   start,
  input  wire eiap_pkg::eiap_payload_t payload,
  input  wire logic [2:0]             len,
  input  wire logic                   out_ready,
  output logic                        out_valid,
  output logic [7:0]                  out_data,
  output logic                        out_last,
  output logic                        busy
);
  import eiap_pkg::*;

  eiap_payload_t shift_r, shift_nxt;
  logic [2:0]    left_r, left_nxt;
  logic          valid_nxt;
  logic          last_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    shift_nxt = shift_r;
    left_nxt  = left_r;
    valid_nxt = out_valid;
    if (start && !out_valid)
    begin
      shift_nxt = payload;
      left_nxt  = len;
      valid_nxt = 1'b1;
    end
    else if (out_valid && out_ready)
    begin
      shift_nxt = {8'h00, shift_r[39:8]};
      left_nxt  = left_r - 3'h1;
      valid_nxt = (left_r != 3'h1);
    end
    // last flag registered so the port comes straight from a flop
    last_nxt = valid_nxt && (left_nxt == 3'h1);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_r   <= 40'h00_0000_0000;
      left_r    <= 3'h0;
      out_valid <= 1'b0;
      out_last  <= 1'b0;
    end
    else
    begin
      shift_r   <= shift_nxt;
      left_r    <= left_nxt;
      out_valid <= valid_nxt;
      out_last  <= last_nxt;
    end
  end

  assign out_data = shift_r[7:0];
  assign busy     = out_valid;
endmodule // eiap_ser

// >>> rtl/eiap_top.sv
// encoder input assembly producer with avalon register slave
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "eiap_params.svh"
module eiap_top
#(
  parameter int          TICK_CYC   = `EIAP_TICK_CYC,
  parameter logic [31:0] RESOLUTION = 32'h0000_2000,
  parameter logic [15:0] ENC_TYPE   = 16'h0000,   // arbitrary value
  parameter logic [31:0] VERSION    = 32'h0001_0001 // arbitrary value
)
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic [31:0] raw_position,
  input  wire logic        alarm_in,
  input  wire logic        poll_req,
  input  wire logic        strobe_req,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output eiap_pkg::eiap_src_e tx_conn,
  output logic             irq
);
  import eiap_pkg::*;

  logic [4:0]    ctrl_r, ctrl_nxt;
  logic          dir_r, dir_nxt;
  logic          scale_r, scale_nxt;
  logic [31:0]   units_r, units_nxt;
  logic [31:0]   range_r, range_nxt;
  logic [31:0]   preset_r, preset_nxt;
  logic [31:0]   offset_r, offset_nxt;
  logic [15:0]   cyc_ms_r, cyc_ms_nxt;
  logic [2:0]    irq_stat_r, irq_stat_nxt;
  logic [2:0]    irq_mask_r, irq_mask_nxt;
  logic [31:0]   rdata_nxt;
  logic          wait_nxt;
  logic          irq_nxt;
  logic          wr_go;
  logic [31:0]   wmask;
  logic [31:0]   dir_pos;
  logic [31:0]   pos_r, pos_nxt;
  logic          alarm_r, alarm_nxt;
  logic [3:0]    pend_r, pend_nxt;
  eiap_src_e     src_r, src_nxt;
  eiap_payload_t last_r, last_nxt;
  eiap_payload_t cur_payload;
  logic [15:0]   tick_cnt_r, tick_cnt_nxt;
  logic [15:0]   ms_cnt_r, ms_cnt_nxt;
  logic          tick;
  logic          cyc_ev;
  logic          cos_ev;
  logic          launch;
  logic          done_ev;
  logic          ser_busy;
  logic          ser_valid;
  logic [7:0]    ser_data;
  logic          ser_last;
  logic [2:0]    len;

  ////////////////////////////////////////////////////////////////////////////
  // position path
  assign dir_pos = dir_r ? (RESOLUTION - 32'h0000_0001 - raw_position) : raw_position;

  always_comb
  begin
    alarm_nxt = alarm_in;
    pos_nxt   = dir_pos + offset_r;
  end

  // payload layout, fixed object set of two input instances
  always_comb
  begin
    if (ctrl_r[`EIAP_CTRL_ASM])
    begin
      cur_payload = {7'h00, alarm_r, pos_r};
      len         = `EIAP_LEN_INST2;
    end
    else
    begin
      cur_payload = {8'h00, pos_r};
      len         = `EIAP_LEN_INST1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave: one wait cycle, answer at the following edge
  assign wr_go = write && !waitrequest;
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                  {8{byteenable[0]}}};

  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    dir_nxt      = dir_r;
    scale_nxt    = scale_r;
    units_nxt    = units_r;
    range_nxt    = range_r;
    preset_nxt   = preset_r;
    offset_nxt   = offset_r;
    cyc_ms_nxt   = cyc_ms_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    wait_nxt     = 1'b1;
    rdata_nxt    = readdata;
    if ((read || write) && waitrequest)
      wait_nxt = 1'b0;
    if (read && waitrequest)
    begin
      case (address)
        `EIAP_OFS_CTRL:      rdata_nxt = {27'h000_0000, ctrl_r};
        `EIAP_OFS_DIR:       rdata_nxt = {31'h0000_0000, dir_r};
        `EIAP_OFS_SCALE:     rdata_nxt = {31'h0000_0000, scale_r};
        `EIAP_OFS_UNITS:     rdata_nxt = units_r;
        `EIAP_OFS_RANGE:     rdata_nxt = range_r;
        `EIAP_OFS_PRESET:    rdata_nxt = preset_r;
        `EIAP_OFS_POSITION:  rdata_nxt = pos_r;
        `EIAP_OFS_RESOL:     rdata_nxt = RESOLUTION;
        `EIAP_OFS_ALARM:     rdata_nxt = {31'h0000_0000, alarm_r};
        `EIAP_OFS_TYPE:      rdata_nxt = {16'h0000, ENC_TYPE};
        `EIAP_OFS_VERSION:   rdata_nxt = VERSION;
        `EIAP_OFS_OFFSET:    rdata_nxt = offset_r;
        `EIAP_OFS_CYC_MS:    rdata_nxt = {16'h0000, cyc_ms_r};
        `EIAP_OFS_IRQ_STAT:  rdata_nxt = {29'h0000_0000, irq_stat_r};
        `EIAP_OFS_IRQ_MASK:  rdata_nxt = {29'h0000_0000, irq_mask_r};
        `EIAP_OFS_CONN_STAT: rdata_nxt = {27'h000_0000, ser_busy, pend_r};
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_go)
    begin
      case (address)
        `EIAP_OFS_CTRL:
          if (byteenable[0])
            ctrl_nxt = writedata[4:0];
        `EIAP_OFS_DIR:
          if (byteenable[0])
            dir_nxt = writedata[0];
        `EIAP_OFS_SCALE:
          if (byteenable[0])
            scale_nxt = writedata[0];
        `EIAP_OFS_UNITS:
          units_nxt = (units_r & ~wmask) | (writedata & wmask);
        `EIAP_OFS_RANGE:
          range_nxt = (range_r & ~wmask) | (writedata & wmask);
        `EIAP_OFS_PRESET:
        begin
          // offset taken against the current shaft reading
          preset_nxt = (preset_r & ~wmask) | (writedata & wmask);
          offset_nxt = preset_nxt - dir_pos;
        end
        `EIAP_OFS_CYC_MS:
          cyc_ms_nxt = (cyc_ms_r & ~wmask[15:0]) | (writedata[15:0] & wmask[15:0]);
        `EIAP_OFS_IRQ_STAT:
          if (byteenable[0])
            irq_stat_nxt = irq_stat_r & ~writedata[2:0];
        `EIAP_OFS_IRQ_MASK:
          if (byteenable[0])
            irq_mask_nxt = writedata[2:0];
        default:
          irq_mask_nxt = irq_mask_r;
      endcase
    end
    // hardware set wins over a same-cycle clear
    if (done_ev)
      irq_stat_nxt[`EIAP_IRQ_SENT] = 1'b1;
    if (alarm_nxt && !alarm_r)
      irq_stat_nxt[`EIAP_IRQ_ALARM] = 1'b1;
    if (wr_go && address == `EIAP_OFS_PRESET)
      irq_stat_nxt[`EIAP_IRQ_PRESET] = 1'b1;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r      <= `EIAP_CTRL_RST;
      dir_r       <= 1'b0;
      scale_r     <= 1'b0;
      units_r     <= 32'h0000_0000;
      range_r     <= 32'h0000_0000;
      preset_r    <= 32'h0000_0000;
      offset_r    <= 32'h0000_0000;
      cyc_ms_r    <= `EIAP_CYC_MS_RST;
      irq_stat_r  <= 3'h0;
      irq_mask_r  <= 3'h0;
      readdata    <= 32'h0000_0000;
      waitrequest <= 1'b1;
      irq         <= 1'b0;
      pos_r       <= 32'h0000_0000;
      alarm_r     <= 1'b0;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      dir_r       <= dir_nxt;
      scale_r     <= scale_nxt;
      units_r     <= units_nxt;
      range_r     <= range_nxt;
      preset_r    <= preset_nxt;
      offset_r    <= offset_nxt;
      cyc_ms_r    <= cyc_ms_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      readdata    <= rdata_nxt;
      waitrequest <= wait_nxt;
      irq         <= irq_nxt;
      pos_r       <= pos_nxt;
      alarm_r     <= alarm_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // millisecond enable and cyclic period
  assign tick   = (tick_cnt_r == 16'(TICK_CYC - 1));
  assign cyc_ev = ctrl_r[`EIAP_CTRL_CYC] && tick && (ms_cnt_r + 16'h0001 >= cyc_ms_r);
  // cos compares against what was last sent, so a missed change is resent
  assign cos_ev = ctrl_r[`EIAP_CTRL_COS] && (cur_payload != last_r);

  always_comb
  begin
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    ms_cnt_nxt   = ms_cnt_r;
    if (!ctrl_r[`EIAP_CTRL_CYC] || cyc_ev)
      ms_cnt_nxt = 16'h0000;
    else if (tick)
      ms_cnt_nxt = ms_cnt_r + 16'h0001;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt_r <= 16'h0000;
      ms_cnt_r   <= 16'h0000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
      ms_cnt_r   <= ms_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger arbitration: poll, strobe, cos, cyclic in that priority
  assign launch  = !ser_busy && (pend_r != 4'h0);
  assign done_ev = tx_valid && tx_ready && tx_last;

  always_comb
  begin
    pend_nxt = pend_r;
    src_nxt  = src_r;
    last_nxt = last_r;
    if (launch)
    begin
      last_nxt = cur_payload;
      if (pend_r[0])
      begin
        pend_nxt[0] = 1'b0;
        src_nxt     = EIAP_SRC_POLL;
      end
      else if (pend_r[1])
      begin
        pend_nxt[1] = 1'b0;
        src_nxt     = EIAP_SRC_STROBE;
      end
      else if (pend_r[2])
      begin
        pend_nxt[2] = 1'b0;
        src_nxt     = EIAP_SRC_COS;
      end
      else
      begin
        pend_nxt[3] = 1'b0;
        src_nxt     = EIAP_SRC_CYC;
      end
    end
    // new poll, strobe and cyclic triggers win over the launch clear
    if (poll_req && ctrl_r[`EIAP_CTRL_POLL])
      pend_nxt[0] = 1'b1;
    if (strobe_req && ctrl_r[`EIAP_CTRL_STROBE])
      pend_nxt[1] = 1'b1;
    // both may be on; the master is expected not to do so
    if (cos_ev && !launch && !ser_busy)
      pend_nxt[2] = 1'b1;
    if (cyc_ev)
      pend_nxt[3] = 1'b1;
    if (!ctrl_r[`EIAP_CTRL_POLL])
      pend_nxt[0] = 1'b0;
    if (!ctrl_r[`EIAP_CTRL_STROBE])
      pend_nxt[1] = 1'b0;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_r <= 4'h0;
      src_r  <= EIAP_SRC_NONE;
      last_r <= 40'h00_0000_0000;
    end
    else
    begin
      pend_r <= pend_nxt;
      src_r  <= src_nxt;
      last_r <= last_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte stream toward the can controller
  eiap_ser u_eiap_ser
  (
    .clock     (clock),
    .rstn      (rstn),
    .start     (launch),
    .payload   (cur_payload),
    .len       (len),
    .out_ready (tx_ready),
    .out_valid (ser_valid),
    .out_data  (ser_data),
    .out_last  (ser_last),
    .busy      (ser_busy)
  );

  assign tx_valid = ser_valid;
  assign tx_data  = ser_data;
  assign tx_last  = ser_last;
  assign tx_conn  = src_r;
endmodule // eiap_top

// >>> sim/eiap_sva.sv
// port assertions for the assembly producer
`timescale 1ns/1ps
module eiap_sva
(
  input wire logic                clock,
  input wire logic                rstn,
  input wire logic                read,
  input wire logic                write,
  input wire logic [31:0]         readdata,
  input wire logic                waitrequest,
  input wire logic                tx_ready,
  input wire logic                tx_valid,
  input wire logic [7:0]          tx_data,
  input wire logic                tx_last,
  input wire eiap_pkg::eiap_src_e tx_conn
);
  import eiap_pkg::*;
  // bytes taken so far in the current frame
  logic [2:0] bcnt_r;
  logic [2:0] bcnt_nxt;
  always_comb
  begin
    bcnt_nxt = bcnt_r;
    if (tx_valid && tx_ready)
      bcnt_nxt = tx_last ? 3'h0 : bcnt_r + 3'h1;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bcnt_r <= 3'h0;
    else
      bcnt_r <= bcnt_nxt;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  bus_answer_a: assert property (s_req |=> s_answer)
    else $error("bus answer not one cycle");
  read_hold_a: assert property ($changed(readdata) |-> $past(read))
    else $error("read data moved without a read");
  byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped before taken");
  frame_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("valid after last byte");
  frame_len_a: assert property (tx_valid && tx_last |-> bcnt_r inside {3'h3, 3'h4})
    else $error("frame length wrong");
  resv_zero_a: assert property (tx_valid && bcnt_r == 3'h4 |-> tx_data[7:1] == 7'h00)
    else $error("reserved bits set");
  conn_code_a: assert property (tx_valid |-> tx_conn inside {[EIAP_SRC_POLL:EIAP_SRC_CYC]})
    else $error("bad frame source");
  first_byte_a: assert property ($rose(tx_valid) |-> !tx_last && bcnt_r == 3'h0)
    else $error("frame starts wrong");
endmodule // eiap_sva
bind eiap_top eiap_sva u_eiap_sva
(
  .clock(clock), .rstn(rstn), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .tx_ready(tx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_conn(tx_conn)
);

// >>> sim/eiap_far.sv
// link-side stand-in: takes payload bytes and logs whole frames
`timescale 1ns/1ps
module eiap_far
(
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire logic                stall,
  input  wire logic                tx_valid,
  input  wire logic [7:0]          tx_data,
  input  wire logic                tx_last,
  input  wire eiap_pkg::eiap_src_e tx_conn,
  output logic                     tx_ready
);
  import eiap_pkg::*;
  logic [1:0]  slow_r;
  logic [39:0] acc;
  int          nb;
  logic [39:0] dq[$];
  int          lq[$];
  eiap_src_e   cq[$];
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      slow_r <= 2'h0;
      tx_ready <= 1'b0;
      acc = 40'h0;
      nb = 0;
    end
    else
    begin
      slow_r <= slow_r + 2'h1;
      // a stalled link takes one byte in four
      tx_ready <= !stall || slow_r == 2'h0;
      if (tx_valid && tx_ready)
      begin
        acc[8*nb +: 8] = tx_data;
        nb++;
        if (tx_last)
        begin
          dq.push_back(acc);
          lq.push_back(nb);
          cq.push_back(tx_conn);
          acc = 40'h0;
          nb = 0;
        end
      end
    end
  end
endmodule // eiap_far

// >>> sim/test_encoder_io_assembly_producer.sv
// self-checking bench for the assembly producer
`timescale 1ns/1ps
`include "eiap_params.svh"
module test_encoder_io_assembly_producer;
  import eiap_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [31:0] raw_position = 32'h0000_0000;
  logic        alarm_in = 1'b0;
  logic        poll_req = 1'b0;
  logic        strobe_req = 1'b0;
  logic        stall = 1'b0;
  logic        tx_ready, tx_valid, tx_last, irq;
  logic [7:0]  tx_data;
  eiap_src_e   tx_conn;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  always #50 clock = ~clock;
  eiap_top #(.TICK_CYC(10), .ENC_TYPE(16'h00A5), .VERSION(32'h0002_0003)) u_eiap_top
  (
    .clock(clock), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .raw_position(raw_position), .alarm_in(alarm_in),
    .poll_req(poll_req), .strobe_req(strobe_req), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_conn(tx_conn),
    .irq(irq)
  );
  eiap_far u_eiap_far
  (
    .clock(clock), .rstn(rstn), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_conn(tx_conn), .tx_ready(tx_ready)
  );
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    tests_run++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    address <= a;
    writedata <= d;
    write <= we;
    read <= !we;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask
  task automatic pulse(input logic p, input logic s);
    poll_req <= p;
    strobe_req <= s;
    @(posedge clock);
    poll_req <= 1'b0;
    strobe_req <= 1'b0;
    @(posedge clock);
  endtask
  task automatic frame(input eiap_src_e c, input int n, input logic [39:0] d);
    while (u_eiap_far.lq.size() == 0)
      @(posedge clock);
    chk("source", 40'(u_eiap_far.cq.pop_front()), 40'(c));
    chk("length", 40'(u_eiap_far.lq.pop_front()), 40'(n));
    chk("bytes", u_eiap_far.dq.pop_front(), d);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    rd("ctrl", `EIAP_OFS_CTRL, 32'h0000_0010);
    rd("period", `EIAP_OFS_CYC_MS, 32'h0000_0064);
    wr(`EIAP_OFS_RESOL, 32'h0000_0000);
    rd("resol", `EIAP_OFS_RESOL, 32'h0000_2000);
    rd("type", `EIAP_OFS_TYPE, 32'h0000_00A5);
    rd("version", `EIAP_OFS_VERSION, 32'h0002_0003);
    wr(`EIAP_OFS_UNITS, 32'h0000_0400);
    rd("units", `EIAP_OFS_UNITS, 32'h0000_0400);
    wr(8'h40, 32'h0000_FFFF);
    rd("unmapped", 8'h40, 32'h0000_0000);
  endtask
  task automatic t_poll();
    raw_position <= 32'h1234_5678;
    stall <= 1'b1;
    wr(`EIAP_OFS_CTRL, 32'h0000_0013);
    pulse(1'b1, 1'b0);
    frame(EIAP_SRC_POLL, 5, 40'h00_1234_5678);
    alarm_in <= 1'b1;
    pulse(1'b1, 1'b0);
    frame(EIAP_SRC_POLL, 5, 40'h01_1234_5678);
    rd("alarm", `EIAP_OFS_ALARM, 32'h0000_0001);
    alarm_in <= 1'b0;
    wr(`EIAP_OFS_CTRL, 32'h0000_0003);
    pulse(1'b1, 1'b0);
    frame(EIAP_SRC_POLL, 4, 40'h00_1234_5678);
    stall <= 1'b0;
  endtask
  task automatic t_both();
    wr(`EIAP_OFS_CTRL, 32'h0000_0013);
    pulse(1'b1, 1'b1);
    frame(EIAP_SRC_POLL, 5, 40'h00_1234_5678);
    frame(EIAP_SRC_STROBE, 5, 40'h00_1234_5678);
    wr(`EIAP_OFS_CTRL, 32'h0000_0010);
    pulse(1'b1, 1'b1);
    repeat (20) @(posedge clock);
    chk("dropped", 40'(u_eiap_far.lq.size()), 40'h0);
  endtask
  // cos and cyclic never enabled together
  task automatic t_cos_cyc();
    wr(`EIAP_OFS_CTRL, 32'h0000_0014);
    raw_position <= 32'h1234_5679;
    frame(EIAP_SRC_COS, 5, 40'h00_1234_5679);
    wr(`EIAP_OFS_CYC_MS, 32'h0000_0002);
    wr(`EIAP_OFS_CTRL, 32'h0000_0018);
    frame(EIAP_SRC_CYC, 5, 40'h00_1234_5679);
    frame(EIAP_SRC_CYC, 5, 40'h00_1234_5679);
    wr(`EIAP_OFS_CTRL, 32'h0000_0011);
    // a cyclic frame may still be under way when the mode is turned off
    repeat (40) @(posedge clock);
    u_eiap_far.dq.delete();
    u_eiap_far.lq.delete();
    u_eiap_far.cq.delete();
  endtask
  task automatic t_preset();
    raw_position <= 32'h0000_0100;
    wr(`EIAP_OFS_DIR, 32'h0000_0001);
    rd("reversed", `EIAP_OFS_POSITION, 32'h0000_1EFF);
    wr(`EIAP_OFS_PRESET, 32'h0000_0500);
    rd("position", `EIAP_OFS_POSITION, 32'h0000_0500);
    rd("offset", `EIAP_OFS_OFFSET, 32'hFFFF_E601);
    pulse(1'b1, 1'b0);
    frame(EIAP_SRC_POLL, 5, 40'h00_0000_0500);
  endtask
  task automatic t_irq();
    rd("status", `EIAP_OFS_IRQ_STAT, 32'h0000_0007);
    chk("irq off", {39'h0, irq}, 40'h0);
    wr(`EIAP_OFS_IRQ_MASK, 32'h0000_0002);
    @(posedge clock);
    chk("irq on", {39'h0, irq}, 40'h1);
    wr(`EIAP_OFS_IRQ_STAT, 32'h0000_0002);
    @(posedge clock);
    chk("irq clr", {39'h0, irq}, 40'h0);
    rd("w1c", `EIAP_OFS_IRQ_STAT, 32'h0000_0005);
  endtask
  initial
  begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_poll();
    t_both();
    t_cos_cyc();
    t_preset();
    t_irq();
    end_of_test();
  end
endmodule // test_encoder_io_assembly_producer
